// *** shared/s1tr_pkg.sv ***
// Constants, register map and field layout of the stage 1 translation bank
package s1tr_pkg;

  // ==========================================================
  // Register byte offsets on the APB
  localparam logic [7:0] S1TR_OFS_CTRL   = 8'h00;
  localparam logic [7:0] S1TR_OFS_EXT    = 8'h04;
  localparam logic [7:0] S1TR_OFS_TB0_LO = 8'h08;
  localparam logic [7:0] S1TR_OFS_TB0_HI = 8'h0c;
  localparam logic [7:0] S1TR_OFS_TB1_LO = 8'h10;
  localparam logic [7:0] S1TR_OFS_TB1_HI = 8'h14;
  localparam logic [7:0] S1TR_OFS_SYND   = 8'h18;
  localparam logic [7:0] S1TR_OFS_STAT   = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int unsigned S1TR_CTRL_EAE_BIT = 31;
  localparam int unsigned S1TR_CTRL_T2E_BIT = 30;
  localparam int unsigned S1TR_EXT_U60_BIT  = 12;
  localparam int unsigned S1TR_EXT_U59_BIT  = 11;
  localparam int unsigned S1TR_EXT_REGION1_HIER_PERM_DISABLE_BIT = 10;
  localparam int unsigned S1TR_EXT_REGION0_HIER_PERM_DISABLE_BIT = 9;
  localparam int unsigned S1TR_CNP_BIT      = 0;
  localparam int unsigned S1TR_AET_LSB      = 14;
  localparam int unsigned S1TR_ST_NARROW    = 0;
  localparam int unsigned S1TR_ST_SECURE    = 1;
  localparam int unsigned S1TR_ST_R0_OFF    = 2;
  localparam int unsigned S1TR_ST_R1_OFF    = 3;
  localparam int unsigned S1TR_ST_LONG      = 4;

  // ==========================================================
  // Masks, encodings and reset values
  localparam logic [31:0] S1TR_CTRL_WMASK = 32'hc000_0000;
  localparam logic [31:0] S1TR_EXT_WMASK  = 32'h0000_1e00;
  localparam logic [1:0]  S1TR_AET_UEU    = 2'h1;
  localparam logic [31:0] S1TR_SYND_VALUE =
    {16'h0000, S1TR_AET_UEU, 14'h0000};
  localparam logic [31:0] S1TR_RST_32 = 32'h0000_0000;
  localparam logic [63:0] S1TR_RST_64 = 64'h0000_0000_0000_0000;
  localparam logic [31:0] S1TR_ZERO_32 = 32'h0000_0000;

  typedef enum logic {
    S1TR_BANK_NS = 1'b0,
    S1TR_BANK_S  = 1'b1
  } s1tr_bank_t;

endpackage : s1tr_pkg

// *** shared/s1tr_reg_if.sv ***
// Carrier between the APB slave and the register bank
`timescale 1ns/100ps
`default_nettype none

interface s1tr_reg_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  modport bus_side (output wr_stb, rd_stb, addr, wdata,
                    input  rdata, hit);
  modport reg_side (input  wr_stb, rd_stb, addr, wdata,
                    output rdata, hit);
endinterface : s1tr_reg_if

`default_nettype wire

// *** rtl/s1tr_apb_slave.sv ***
// APB protocol front end: strobes, read data and error capture
`timescale 1ns/100ps
`default_nettype none

module s1tr_apb_slave
  import s1tr_pkg::*;
(
  input  wire logic        pclk,    // Bus clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        psel,    // Slave select
  input  wire logic        penable, // Access phase
  input  wire logic        pwrite,  // Write direction
  input  wire logic [7:0]  paddr,   // Byte address
  input  wire logic [31:0] pwdata,  // Write data
  output logic      [31:0] prdata,  // Read data
  output logic             pready,  // Always ready
  output logic             pslverr, // Unmapped address
  s1tr_reg_if.bus_side     regs     // Register side
);

  // ==========================================================
  // Strobes
  logic        setup_w;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  assign setup_w     = psel & ~penable;
  assign regs.wr_stb = psel & penable & pwrite;
  assign regs.rd_stb = setup_w & ~pwrite;
  assign regs.addr   = paddr;
  assign regs.wdata  = pwdata;
  assign pready      = 1'b1;
  assign prdata      = prdata_q;
  assign pslverr     = pslverr_q;

  // ==========================================================
  // Answer is prepared in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= S1TR_RST_32;
      pslverr_q <= 1'b0;
    end else if (setup_w) begin
      prdata_q  <= regs.rd_stb ? regs.rdata : S1TR_ZERO_32;
      pslverr_q <= ~regs.hit;
    end
  end

endmodule : s1tr_apb_slave

`default_nettype wire

// *** rtl/s1tr_base_reg.sv ***
// One 64-bit table base register written as two 32-bit words
`timescale 1ns/100ps
`default_nettype none

module s1tr_base_reg
  import s1tr_pkg::*;
(
  input  wire logic        pclk,    // Clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        wr_lo,   // Write low word
  input  wire logic        wr_hi,   // Write high word
  input  wire logic [31:0] wdata,   // Write data
  output logic      [63:0] value    // Stored value
);

  logic [63:0] value_q;

  assign value = value_q;

  // Each half only moves on its own strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= S1TR_RST_64;
    end else begin
      if (wr_lo) value_q[31:0]  <= wdata;
      if (wr_hi) value_q[63:32] <= wdata;
    end
  end

endmodule : s1tr_base_reg

`default_nettype wire

// *** rtl/s1tr_bank.sv ***
// Stage 1 translation control, table base and syndrome register bank
//
// Notes on behaviour
// RQ1: Region-0 use of descriptor bits 60/59 needs enable and region-0 disable.
// RQ2: With a use enable at zero, the descriptor bit is never interpreted.
// RQ3: Region-1 hierarchy disable acts only together with extended control.
// RQ4: Region-0 hierarchy disable acts only together with extended control.
// RQ5: With EL3 in 32-bit state, control and base 0 are banked; the code banks extended control and base 0, and base control has one copy.
// RQ6: With EL3 in 64-bit state, base 1 has a single copy.
// RQ7: A 32-bit access touches only the low word of a base.
// RQ8: Short format ignores the upper base word; long format uses all.
// RQ9: In long format bit 0 of each base is common-not-private.
// RQ10: Syndrome register supplies the value seen on a virtual error.
// RQ11: Error type field holds 0b01, uncorrected and unrecoverable.
// RQ12: Abort type bit and all other syndrome bits are reserved zero.
// RQ13: Extended address enable at bit 31 selects the long format.
// RQ14: Reserved-zero bits read zero; writes to them change nothing.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module s1tr_bank
  import s1tr_pkg::*;
(
  input  wire logic        pclk,            // Clock, 100 MHz
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        el3_narrow_pin,  // EL3 runs 32-bit state
  input  wire logic        secure_state,    // Core is in Secure state
  input  wire logic        vserr_take,      // Virtual error taken
  output logic             use_bit60_grant, // Desc bit 60 usable
  output logic             use_bit59_grant, // Desc bit 59 usable
  output logic             r0_hier_off,     // Region 0 hierarchy off
  output logic             r1_hier_off,     // Region 1 hierarchy off
  output logic             long_format,     // Long descriptors
  output logic      [63:0] base_zero_eff,   // Effective base 0
  output logic      [63:0] base_one_eff,    // Effective base 1
  output logic             cnp_zero,        // Base 0 common flag
  output logic             cnp_one,         // Base 1 common flag
  output logic      [31:0] vserr_syndrome   // Syndrome on take
);

  // ==========================================================
  // APB front end
  s1tr_reg_if regs ();

  s1tr_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs)
  );

  // ==========================================================
  // Execution state strap
  // The pin comes from outside, so it is synchronised, then
  // caught once after reset release and held until next reset.
  // The fill flags hold the catch back until a real pin sample
  // has reached the second stage instead of its reset zero.
  logic narrow_s1_q;
  logic narrow_s2_q;
  logic fill1_q;
  logic fill2_q;
  logic narrow_q;
  logic strap_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_s1_q <= 1'b0;
      narrow_s2_q <= 1'b0;
      fill1_q     <= 1'b0;
      fill2_q     <= 1'b0;
    end else begin
      narrow_s1_q <= el3_narrow_pin;
      narrow_s2_q <= narrow_s1_q;
      fill1_q     <= 1'b1;
      fill2_q     <= fill1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_q     <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (fill2_q && !strap_done_q) begin
      narrow_q     <= narrow_s2_q;
      strap_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Bank selection
  // Without banking every access lands on the Non-secure copy.
  // The security state comes from core logic on this clock, so
  // it steers the bank directly with no synchroniser.
  s1tr_bank_t bank_w;

  assign bank_w = (narrow_q && secure_state) ? S1TR_BANK_S
                                             : S1TR_BANK_NS; // RQ5

  // ==========================================================
  // Address decode
  logic sel_ctrl;
  logic sel_ext;
  logic sel_tb0_lo;
  logic sel_tb0_hi;
  logic sel_tb1_lo;
  logic sel_tb1_hi;
  logic sel_synd;
  logic sel_stat;
  logic wr_ctrl;
  logic wr_ext;

  assign sel_ctrl   = regs.addr == S1TR_OFS_CTRL;
  assign sel_ext    = regs.addr == S1TR_OFS_EXT;
  assign sel_tb0_lo = regs.addr == S1TR_OFS_TB0_LO;
  assign sel_tb0_hi = regs.addr == S1TR_OFS_TB0_HI;
  assign sel_tb1_lo = regs.addr == S1TR_OFS_TB1_LO;
  assign sel_tb1_hi = regs.addr == S1TR_OFS_TB1_HI;
  assign sel_synd   = regs.addr == S1TR_OFS_SYND;
  assign sel_stat   = regs.addr == S1TR_OFS_STAT;

  assign regs.hit = sel_ctrl | sel_ext | sel_tb0_lo | sel_tb0_hi |
                    sel_tb1_lo | sel_tb1_hi | sel_synd | sel_stat;

  assign wr_ctrl = regs.wr_stb & sel_ctrl;
  assign wr_ext  = regs.wr_stb & sel_ext;

  // ==========================================================
  // Base control: format and extended-control enables
  logic eae_q;
  logic t2e_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eae_q <= 1'b0;
      t2e_q <= 1'b0;
    end else if (wr_ctrl) begin
      eae_q <= regs.wdata[S1TR_CTRL_EAE_BIT]; // RQ13
      t2e_q <= regs.wdata[S1TR_CTRL_T2E_BIT];
    end
  end

  // ==========================================================
  // Extended control, one copy per security bank
  // Only the four implemented fields are stored; everything
  // else is dropped on write so it can never steer the walk.
  logic [31:0] ext_q   [2];
  logic [63:0] tb0_val [2];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic bank_hit;

    assign bank_hit = bank_w == s1tr_bank_t'(b);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ext_q[b] <= S1TR_RST_32;
      end else if (wr_ext && bank_hit) begin
        ext_q[b] <= regs.wdata & S1TR_EXT_WMASK; // RQ14
      end
    end

    s1tr_base_reg u_tb0 (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_lo   (regs.wr_stb & sel_tb0_lo & bank_hit), // RQ7
      .wr_hi   (regs.wr_stb & sel_tb0_hi & bank_hit),
      .wdata   (regs.wdata),
      .value   (tb0_val[b])
    );
  end : g_bank

  // ==========================================================
  // Table base one: a single copy in every configuration
  logic [63:0] tb1_val;

  s1tr_base_reg u_tb1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (regs.wr_stb & sel_tb1_lo), // RQ6 RQ7
    .wr_hi   (regs.wr_stb & sel_tb1_hi),
    .wdata   (regs.wdata),
    .value   (tb1_val)
  );

  // ==========================================================
  // Current copies seen by translation and by software
  logic [31:0] ext_cur;
  logic [63:0] tb0_cur;

  assign ext_cur = ext_q[bank_w];
  assign tb0_cur = tb0_val[bank_w];

  // ==========================================================
  // Effective translation controls
  logic region0_hier_perm_disable_eff;
  logic region1_hier_perm_disable_eff;
  logic u60_eff;
  logic u59_eff;

  assign region0_hier_perm_disable_eff = ext_cur[S1TR_EXT_REGION0_HIER_PERM_DISABLE_BIT] & t2e_q; // RQ4
  assign region1_hier_perm_disable_eff = ext_cur[S1TR_EXT_REGION1_HIER_PERM_DISABLE_BIT] & t2e_q; // RQ3
  // A clear use enable forces the grant low whatever else holds
  assign u60_eff  = ext_cur[S1TR_EXT_U60_BIT] & region0_hier_perm_disable_eff; // RQ1 RQ2
  assign u59_eff  = ext_cur[S1TR_EXT_U59_BIT] & region0_hier_perm_disable_eff; // RQ1 RQ2

  // ==========================================================
  // Effective base values
  // In short format the upper word is still stored and readable,
  // but translation sees zeros there.
  logic [63:0] tb0_eff_w;
  logic [63:0] tb1_eff_w;
  logic        cnp0_w;
  logic        cnp1_w;

  assign tb0_eff_w = eae_q ? tb0_cur
                           : {S1TR_ZERO_32, tb0_cur[31:0]}; // RQ8
  assign tb1_eff_w = eae_q ? tb1_val
                           : {S1TR_ZERO_32, tb1_val[31:0]}; // RQ8
  assign cnp0_w    = eae_q & tb0_cur[S1TR_CNP_BIT]; // RQ9
  assign cnp1_w    = eae_q & tb1_val[S1TR_CNP_BIT]; // RQ9

  // ==========================================================
  // Registered outputs toward the translation logic
  // One cycle of latency is traded for keeping the decode and
  // bank selection paths out of the translation timing.
  logic        u60_q;
  logic        u59_q;
  logic        region0_hier_perm_disable_q;
  logic        region1_hier_perm_disable_q;
  logic        long_q;
  logic [63:0] tb0_eff_q;
  logic [63:0] tb1_eff_q;
  logic        cnp0_q;
  logic        cnp1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u60_q  <= 1'b0;
      u59_q  <= 1'b0;
      region0_hier_perm_disable_q <= 1'b0;
      region1_hier_perm_disable_q <= 1'b0;
      long_q <= 1'b0;
    end else begin
      u60_q  <= u60_eff;
      u59_q  <= u59_eff;
      region0_hier_perm_disable_q <= region0_hier_perm_disable_eff;
      region1_hier_perm_disable_q <= region1_hier_perm_disable_eff;
      long_q <= eae_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb0_eff_q <= S1TR_RST_64;
      tb1_eff_q <= S1TR_RST_64;
      cnp0_q    <= 1'b0;
      cnp1_q    <= 1'b0;
    end else begin
      tb0_eff_q <= tb0_eff_w;
      tb1_eff_q <= tb1_eff_w;
      cnp0_q    <= cnp0_w;
      cnp1_q    <= cnp1_w;
    end
  end

  assign use_bit60_grant = u60_q;
  assign use_bit59_grant = u59_q;
  assign r0_hier_off     = region0_hier_perm_disable_q;
  assign r1_hier_off     = region1_hier_perm_disable_q;
  assign long_format     = long_q;
  assign base_zero_eff   = tb0_eff_q;
  assign base_one_eff    = tb1_eff_q;
  assign cnp_zero        = cnp0_q;
  assign cnp_one         = cnp1_q;

  // ==========================================================
  // Virtual error syndrome
  // Only external aborts are reported, so every field but the
  // error type is fixed at zero and the register holds no state
  // a write could disturb.
  logic [31:0] synd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synd_q <= S1TR_RST_32;
    end else if (vserr_take) begin
      synd_q <= S1TR_SYND_VALUE; // RQ10 RQ11 RQ12
    end
  end

  assign vserr_syndrome = synd_q;

  // ==========================================================
  // Status word for software
  logic [31:0] stat_w;

  always_comb begin
    stat_w                 = S1TR_ZERO_32;
    stat_w[S1TR_ST_NARROW] = narrow_q;
    stat_w[S1TR_ST_SECURE] = secure_state;
    stat_w[S1TR_ST_R0_OFF] = region0_hier_perm_disable_eff;
    stat_w[S1TR_ST_R1_OFF] = region1_hier_perm_disable_eff;
    stat_w[S1TR_ST_LONG]   = eae_q;
  end

  // ==========================================================
  // Read multiplexer
  // Status and syndrome words are read-only; a write to either
  // lands nowhere and only costs a bus cycle.
  logic [31:0] ctrl_rd;

  assign ctrl_rd = {eae_q, t2e_q, 30'h0} & S1TR_CTRL_WMASK;

  always_comb begin
    case (regs.addr)
      S1TR_OFS_CTRL:   regs.rdata = ctrl_rd;
      S1TR_OFS_EXT:    regs.rdata = ext_cur; // RQ14
      S1TR_OFS_TB0_LO: regs.rdata = tb0_cur[31:0]; // RQ7
      S1TR_OFS_TB0_HI: regs.rdata = tb0_cur[63:32];
      S1TR_OFS_TB1_LO: regs.rdata = tb1_val[31:0]; // RQ7
      S1TR_OFS_TB1_HI: regs.rdata = tb1_val[63:32];
      S1TR_OFS_SYND:   regs.rdata = S1TR_SYND_VALUE; // RQ11 RQ12
      S1TR_OFS_STAT:   regs.rdata = stat_w;
      default:         regs.rdata = S1TR_ZERO_32;
    endcase
  end

endmodule : s1tr_bank

`default_nettype wire

// *** dv/s1tr_bank_props.sv ***
// Assertions on the ports of the stage 1 translation register bank
`timescale 1ns/100ps
`default_nettype none

module s1tr_bank_props
  import s1tr_pkg::*;
(
  input wire logic        pclk,            // Clock
  input wire logic        presetn,         // Reset
  input wire logic        psel,            // Select
  input wire logic        penable,         // Access
  input wire logic        pwrite,          // Write
  input wire logic [7:0]  paddr,           // Address
  input wire logic [31:0] pwdata,          // Write data
  input wire logic [31:0] prdata,          // Read data
  input wire logic        vserr_take,      // Error taken
  input wire logic        use_bit60_grant, // Bit 60 use
  input wire logic        use_bit59_grant, // Bit 59 use
  input wire logic        r0_hier_off,     // Region 0 off
  input wire logic        long_format,     // Long format
  input wire logic [63:0] base_zero_eff,   // Base 0
  input wire logic [63:0] base_one_eff,    // Base 1
  input wire logic        cnp_zero,        // Base 0 flag
  input wire logic        cnp_one,         // Base 1 flag
  input wire logic [31:0] vserr_syndrome   // Syndrome
);
  // ==========================================================
  // Access decode
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire rd_acc = psel && penable && !pwrite;
  wire wr_acc = psel && penable && pwrite;

  sequence ctrl_wr_s;
    wr_acc && paddr == S1TR_OFS_CTRL;
  endsequence
  sequence base1_lo_wr_s;
    wr_acc && paddr == S1TR_OFS_TB1_LO;
  endsequence

  // ==========================================================
  // Properties
  // Outputs lag the register by one edge, so writes show after ##2
  eae_select_a: assert property (ctrl_wr_s |-> ##2
    long_format == $past(pwdata[31], 2)) else $error("format not set");
  lo_keeps_hi_a: assert property (base1_lo_wr_s |-> ##2
    $stable(base_one_eff[63:32])) else $error("upper base word moved");
  use60_needs_a: assert property (use_bit60_grant |-> r0_hier_off)
    else $error("bit 60 use without hierarchy disable");
  use59_needs_a: assert property (use_bit59_grant |-> r0_hier_off)
    else $error("bit 59 use without hierarchy disable");
  short_upper_a: assert property (!long_format |->
    base_zero_eff[63:32] == 32'h0 && base_one_eff[63:32] == 32'h0)
    else $error("upper base word used in short format");
  cnp_zero_a: assert property (
    cnp_zero == (long_format && base_zero_eff[0]))
    else $error("base 0 common flag wrong");
  cnp_one_a: assert property (
    cnp_one == (long_format && base_one_eff[0]))
    else $error("base 1 common flag wrong");
  synd_take_a: assert property (vserr_take |=>
    vserr_syndrome == 32'h0000_4000) else $error("syndrome not loaded");
  synd_resv_a: assert property (
    (vserr_syndrome & 32'hffff_3fff) == 32'h0000_0000)
    else $error("syndrome reserved bit set");
  synd_read_a: assert property (rd_acc && paddr == S1TR_OFS_SYND |->
    prdata == 32'h0000_4000) else $error("syndrome read wrong");
  ext_resv_a: assert property (rd_acc && paddr == S1TR_OFS_EXT |->
    (prdata & 32'hffff_e1ff) == 32'h0000_0000)
    else $error("reserved control bit read nonzero");
endmodule : s1tr_bank_props

bind s1tr_bank s1tr_bank_props s1tr_bank_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .vserr_take(vserr_take), .use_bit60_grant(use_bit60_grant),
  .use_bit59_grant(use_bit59_grant), .r0_hier_off(r0_hier_off),
  .long_format(long_format), .base_zero_eff(base_zero_eff),
  .base_one_eff(base_one_eff), .cnp_zero(cnp_zero), .cnp_one(cnp_one),
  .vserr_syndrome(vserr_syndrome)
);

`default_nettype wire

// *** dv/test_s1tr_bank.sv ***
// Self-checking testbench for the stage 1 translation register bank
`timescale 1ns/100ps
`default_nettype none

module test_s1tr_bank
  import s1tr_pkg::*;
();
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        narrow = 1'b0, secure = 1'b0, take = 1'b0;
  logic [31:0] prdata, syn;
  logic        pready, pslverr, g60, g59, h0, h1, lf, cz, co;
  logic [63:0] bz, bo;
  int          mismatches = 0;
  int          compares = 0;

  always #5 pclk = ~pclk;

  s1tr_bank s1tr_bank_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .el3_narrow_pin(narrow),
    .secure_state(secure), .vserr_take(take), .use_bit60_grant(g60),
    .use_bit59_grant(g59), .r0_hier_off(h0), .r1_hier_off(h1),
    .long_format(lf), .base_zero_eff(bz), .base_one_eff(bo),
    .cnp_zero(cz), .cnp_one(co), .vserr_syndrome(syn)
  );

  // ==========================================================
  // Common tasks
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [63:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Always opens on a fresh edge, so one idle cycle sits between transfers
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test;
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write error", 0, e);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(what, exp, r);
  endtask : rdchk

  // Translation outputs follow the register one edge later
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask : settle

  task automatic do_reset(input logic strap);
    @(posedge pclk);
    presetn <= 1'b0;
    narrow <= strap;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    chk("pready", 1, pready);
    chk("syndrome before take", 0, syn);
    for (int i = 0; i < 6; i++) rdchk("reset word", 8'(i * 4), 0);
    rdchk("syndrome read", S1TR_OFS_SYND, 32'h0000_4000);
  endtask : t_reset_values

  task automatic t_refusals;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    chk("unmapped read error", 1, e);
    chk("unmapped read data", 0, r);
    apb(1'b1, 8'hfc, 32'hffff_ffff, r, e);
    chk("unmapped write error", 1, e);
    wr(S1TR_OFS_SYND, 32'hffff_ffff);
    rdchk("syndrome after write", S1TR_OFS_SYND, 32'h0000_4000);
    wr(S1TR_OFS_EXT, 32'hffff_ffff);
    rdchk("ext reserved", S1TR_OFS_EXT, 32'h0000_1e00);
    wr(S1TR_OFS_CTRL, 32'hffff_ffff);
    rdchk("ctrl reserved", S1TR_OFS_CTRL, 32'hc000_0000);
    wr(S1TR_OFS_CTRL, 32'h0000_0000);
  endtask : t_refusals

  task automatic t_hierarchy;
    for (int i = 0; i < 32; i++) begin
      wr(S1TR_OFS_CTRL, {1'b0, i[4], 30'h0000_0000});
      wr(S1TR_OFS_EXT, {19'h0_0000, i[3:0], 9'h000});
      settle;
      chk("region0 off", i[4] & i[0], h0);
      chk("region1 off", i[4] & i[1], h1);
      chk("use bit59", i[4] & i[0] & i[2], g59);
      chk("use bit60", i[4] & i[0] & i[3], g60);
    end
    wr(S1TR_OFS_CTRL, 32'h0000_0000);
  endtask : t_hierarchy

  task automatic t_bases;
    logic [7:0] lo;
    for (int k = 0; k < 2; k++) begin
      lo = (k == 1) ? S1TR_OFS_TB1_LO : S1TR_OFS_TB0_LO;
      wr(lo + 8'h04, 32'h1234_5678);
      wr(lo, 32'h9abc_def0);
      wr(lo, 32'h5555_aaa1);
      rdchk("base high kept", lo + 8'h04, 32'h1234_5678);
      rdchk("base low", lo, 32'h5555_aaa1);
    end
    settle;
    chk("short base0", 64'h0000_0000_5555_aaa1, bz);
    chk("short base1", 64'h0000_0000_5555_aaa1, bo);
    chk("short flags", 0, {cz, co});
    wr(S1TR_OFS_CTRL, 32'h8000_0000);
    settle;
    chk("long format", 1, lf);
    chk("long base0", 64'h1234_5678_5555_aaa1, bz);
    chk("long base1", 64'h1234_5678_5555_aaa1, bo);
    chk("long flags", 2'b11, {cz, co});
    wr(S1TR_OFS_TB1_LO, 32'h5555_aaa0);
    settle;
    chk("flag cleared", 2'b10, {cz, co});
  endtask : t_bases

  task automatic t_banking;
    do_reset(1'b1);
    secure <= 1'b1;
    wr(S1TR_OFS_EXT, 32'h0000_0200);
    wr(S1TR_OFS_TB0_LO, 32'h0000_00a0);
    wr(S1TR_OFS_TB1_LO, 32'h0000_00b0);
    @(posedge pclk);
    secure <= 1'b0;
    rdchk("ns ext copy", S1TR_OFS_EXT, 32'h0000_0000);
    rdchk("ns base0 copy", S1TR_OFS_TB0_LO, 32'h0000_0000);
    rdchk("shared base1", S1TR_OFS_TB1_LO, 32'h0000_00b0);
    @(posedge pclk);
    secure <= 1'b1;
    rdchk("s ext copy", S1TR_OFS_EXT, 32'h0000_0200);
    rdchk("s base0 copy", S1TR_OFS_TB0_LO, 32'h0000_00a0);
    rdchk("s status", S1TR_OFS_STAT, 32'h0000_0003);
    wr(S1TR_OFS_CTRL, 32'h4000_0000);
    settle;
    chk("s region0 off", 1, h0);
    @(posedge pclk);
    secure <= 1'b0;
    settle;
    chk("ns region0 off", 0, h0);
    rdchk("ns status", S1TR_OFS_STAT, 32'h0000_0001);
  endtask : t_banking

  task automatic t_syndrome;
    @(posedge pclk);
    take <= 1'b1;
    @(posedge pclk);
    take <= 1'b0;
    settle;
    chk("syndrome on take", 32'h0000_4000, syn);
  endtask : t_syndrome

  initial begin
    do_reset(1'b0);
    t_reset_values;
    t_refusals;
    t_hierarchy;
    t_bases;
    t_banking;
    t_syndrome;
    finish_test;
  end
endmodule : test_s1tr_bank

`default_nettype wire
